// File: hdl/lcd_frame_control.sv
// The plain strobed port and the placing of the registers are this design's own decisions.
`include "lfc_map.svh"

// Overview of operation
// R01: Latch memory, blank, wave, contrast at frame
// R02: Register writes accepted at any time
// R03: Enable starts; clearing stops and frees pins
// R04: Waveform select applies from next frame
// R05: Frame flag set when data latched
// R06: Interrupt when flag, enable, global enable
// R07: Flag cleared by vector or written one
// R08: Low-power waveform flags every second frame
// R09: Software masks flag in read-modify-write
// R10: Reserved bits read as zero
// R11: Blank after frame, drive pins ground
// R12: Clock select picks system or async clock
// R13: Async source from oscillator or external input
// R14: Bias select: third or half, non-static
// R15: Duty field chooses one to four commons
// R16: Port mask chooses 13 to 25 segments
// R17: Software disable sequence uses blanking, flag
// R18: Software discharges glass before disabling
// R19: Software keeps display port pins safe
// R20: Software disables before re-initialising
// R21: Software updates from frame interrupt
// R22: Blanking preserves display memory
// R23: Low-power latches data every second frame
// R24: Control bits reset to zero
// R25: Frame strobe synchronised into register domain
module lcd_frame_control
    import lfc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic global_irq_enable,
    input wire logic irq_vector_taken,
    input wire logic async_osc_clk,
    input wire logic ext_clock_pin,
    input wire logic ext_clock_input_enable,
    output logic frame_irq,
    output logic frame_start,
    output logic display_active,
    output logic blanked,
    output logic low_power_wave,
    output logic half_bias,
    output logic [3:0] contrast_latched,
    output logic [3:0] common_enable,
    output logic [24:0] segment_enable,
    output logic [55:0] display_latched
);
    logic rst_meta;
    logic rst_sync_n;
    logic display_enable;
    logic low_power_wave_sel;
    logic frame_irq_flag;
    logic frame_irq_enable;
    logic blank_display;
    logic display_clock_sel;
    logic half_bias_sel;
    logic [1:0] duty_select;
    logic [2:0] segment_port_mask;
    logic [3:0] contrast_setting;
    logic [7:0] frame_len;
    logic [7:0] frame_cnt;
    logic osc_meta;
    logic osc_sync;
    logic ext_meta;
    logic ext_sync;
    logic async_lvl;
    logic async_prev;
    logic async_tick;
    logic frame_tick;
    logic odd_frame;
    logic latch_now;
    logic [2:0] lat_idx;
    logic lat_busy;
    logic lat_hold;
    logic [2:0] mem_rd_addr;
    logic [7:0] mem_rd_data;
    logic mem_wr;
    logic rd_pending;
    logic [3:0] rd_addr_q;
    logic [7:0] next_rdata;
    lfc_state_t state;

    function automatic logic [4:0] seg_count(input logic [2:0] code);
        case (code)
            3'h6: seg_count = `LFC_SEG_24;
            3'h7: seg_count = `LFC_SEG_25;
            default: seg_count = 5'(`LFC_SEG_BASE + {code, 1'b0});
        endcase
    endfunction

    function automatic logic is_addr(input logic [3:0] a, input logic [3:0] b);
        is_addr = (a == b);
    endfunction

    function automatic logic is_mem(input logic [3:0] a);
        is_mem = (a >= `LFC_ADDR_MEM_BASE) && (a < 4'(`LFC_ADDR_MEM_BASE + `LFC_MEM_WORDS));
    endfunction

    // A frame lasts at least 16 ticks, long enough for the word-by-word memory copy of the last one unless bus reads of memory stall it.
    function automatic logic frame_done(input logic [7:0] cnt, input logic [7:0] len);
        frame_done = (cnt >= len) && (cnt >= `LFC_FRAME_MIN_TICKS);
    endfunction

    // Reset leaves through two flip-flops so that every register outside the display memory comes out of it on one edge.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // The slow display clocks arrive from pins and pass two flip-flops.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            async_prev <= 1'b0;
        end else begin
            osc_meta <= async_osc_clk;
            osc_sync <= osc_meta;
            ext_meta <= ext_clock_pin;
            ext_sync <= ext_meta;
            async_prev <= async_lvl;
        end
    end

    assign async_lvl = ext_clock_input_enable ? ext_sync : osc_sync; // see R13
    assign async_tick = async_lvl & ~async_prev; // see R25

    // Frame timer: counts display clock ticks from the selected source.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            frame_cnt <= 8'h00;
        end else if (!display_enable) begin
            frame_cnt <= 8'h00;
        end else if (display_clock_sel ? async_tick : 1'b1) begin // see R12
            frame_cnt <= frame_done(frame_cnt, frame_len) ? 8'h00 : 8'(frame_cnt + 8'h01);
        end
    end

    assign frame_tick = display_enable && (display_clock_sel ? async_tick : 1'b1)
        && frame_done(frame_cnt, frame_len);
    assign latch_now = frame_tick && (!low_power_wave || !odd_frame); // see R08 R23

    // Frame parity, so that the low-power waveform can skip every second latch.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            odd_frame <= 1'b0;
        end else if (!display_enable) begin
            odd_frame <= 1'b0;
        end else if (frame_tick) begin
            odd_frame <= ~odd_frame;
        end
    end

    assign mem_wr = reg_wr && is_mem(reg_addr); // see R02

    // A bus read of display memory owns the read port for its cycle; the frame copy waits for it.
    assign lat_hold = reg_rd && is_mem(reg_addr);

    // Control registers; all writable bits reset to zero except frame_len, which resets to 8'h0F.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            display_enable <= 1'b0; // see R24
            low_power_wave_sel <= 1'b0;
            frame_irq_enable <= 1'b0;
            blank_display <= 1'b0;
            display_clock_sel <= 1'b0;
            half_bias_sel <= 1'b0;
            duty_select <= 2'h0;
            segment_port_mask <= 3'h0;
            contrast_setting <= 4'h0;
            frame_len <= `LFC_FRAME_LEN_RESET;
        end else if (reg_wr) begin
            if (is_addr(reg_addr, `LFC_ADDR_CTRL_A)) begin
                display_enable <= reg_wdata[`LFC_A_ENABLE]; // see R03
                low_power_wave_sel <= reg_wdata[`LFC_A_LOW_POWER];
                frame_irq_enable <= reg_wdata[`LFC_A_IRQ_EN];
                blank_display <= reg_wdata[`LFC_A_BLANK];
            end
            if (is_addr(reg_addr, `LFC_ADDR_CTRL_B)) begin
                display_clock_sel <= reg_wdata[`LFC_B_CLK_SEL];
                half_bias_sel <= reg_wdata[`LFC_B_HALF_BIAS];
                duty_select <= reg_wdata[`LFC_B_DUTY_HI:`LFC_B_DUTY_LO];
                segment_port_mask <= reg_wdata[2:0];
            end
            if (is_addr(reg_addr, `LFC_ADDR_CONTRAST)) begin
                contrast_setting <= reg_wdata[3:0];
            end
            if (is_addr(reg_addr, `LFC_ADDR_FRAME_LEN)) begin
                frame_len <= reg_wdata;
            end
        end
    end

    // A new frame start wins over a clear in the same cycle.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            frame_irq_flag <= 1'b0;
        end else if (latch_now) begin
            frame_irq_flag <= 1'b1; // see R05
        end else if (irq_vector_taken
            || (reg_wr && is_addr(reg_addr, `LFC_ADDR_CTRL_A) && reg_wdata[`LFC_A_FLAG])) begin
            frame_irq_flag <= 1'b0; // see R07
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            frame_irq <= 1'b0;
            frame_start <= 1'b0;
        end else begin
            // Looking at latch_now lets the request rise together with the flag.
            frame_irq <= (frame_irq_flag || latch_now) && frame_irq_enable && global_irq_enable; // see R06
            frame_start <= latch_now;
        end
    end

    // Settings latched at the frame boundary.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            low_power_wave <= 1'b0;
            contrast_latched <= 4'h0;
            state <= LFC_OFF;
        end else if (!display_enable) begin
            state <= LFC_OFF; // see R03
        end else if (latch_now) begin
            low_power_wave <= low_power_wave_sel; // see R01 R04
            contrast_latched <= contrast_setting;
            case (state)
                LFC_OFF: state <= LFC_RUN;
                LFC_RUN: state <= blank_display ? LFC_BLANKED : LFC_RUN; // see R11
                LFC_BLANKED: state <= blank_display ? LFC_BLANKED : LFC_RUN;
                default: state <= LFC_OFF;
            endcase
        end
    end

    // Display memory is copied word by word after the latch point; blanking never touches it.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            lat_busy <= 1'b0;
            lat_idx <= 3'h0;
        end else if (latch_now) begin
            lat_busy <= 1'b1; // see R01
            lat_idx <= 3'h0;
        end else if (lat_busy && !lat_hold) begin
            lat_idx <= 3'(lat_idx + 3'h1);
            lat_busy <= (lat_idx != 3'(`LFC_MEM_WORDS - 4'h1));
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rd_pending <= 1'b0;
            display_latched <= 56'h0;
        end else begin
            rd_pending <= lat_busy && !lat_hold;
            if (rd_pending) begin
                display_latched[8*(lat_idx - 3'h1) +: 8] <= mem_rd_data; // see R22
            end
        end
    end

    assign mem_rd_addr = (lat_busy && !lat_hold) ? lat_idx : 3'(reg_addr - `LFC_ADDR_MEM_BASE);

    lfc_display_mem u_mem (
        .sys_clk(sys_clk),
        .wr_en(mem_wr),
        .wr_addr(3'(reg_addr - `LFC_ADDR_MEM_BASE)),
        .wr_data(reg_wdata),
        .rd_addr(mem_rd_addr),
        .rd_data(mem_rd_data)
    );

    // Pin ownership and drive level.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            display_active <= 1'b0;
            blanked <= 1'b0;
            half_bias <= 1'b0;
            common_enable <= 4'h0;
            segment_enable <= 25'h0;
        end else begin
            display_active <= display_enable; // see R03
            blanked <= display_enable && state == LFC_BLANKED; // see R11
            half_bias <= half_bias_sel && duty_select != 2'h0; // see R14
            common_enable <= display_enable ? 4'((5'h02 << duty_select) - 5'h01) : 4'h0; // see R15
            for (int i = 0; i < `LFC_SEG_PINS; i++) begin
                segment_enable[i] <= display_enable && (5'(i) < seg_count(segment_port_mask)); // see R16
            end
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        case (rd_addr_q)
            `LFC_ADDR_CTRL_A: next_rdata = {display_enable, low_power_wave_sel, 1'b0, frame_irq_flag,
                                            frame_irq_enable, 2'b00, blank_display}; // see R10
            `LFC_ADDR_CTRL_B: next_rdata = {display_clock_sel, half_bias_sel, duty_select, 1'b0,
                                            segment_port_mask};
            `LFC_ADDR_CONTRAST: next_rdata = {4'h0, contrast_setting};
            `LFC_ADDR_FRAME_LEN: next_rdata = frame_len;
            `LFC_ADDR_STATUS: next_rdata = {5'h00, state};
            default: next_rdata = is_mem(rd_addr_q) ? mem_rd_data : 8'h00;
        endcase
    end

    logic rd_q;
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rd_q <= 1'b0;
            rd_addr_q <= 4'h0;
        end else begin
            rd_q <= reg_rd;
            rd_addr_q <= reg_addr;
        end
    end

    // Read data is gated rather than registered: memory words already spend the
    // strobe cycle in the memory's own read register and must still answer one cycle later.
    assign reg_rdata = rd_q ? next_rdata : 8'h00;
endmodule

// File: hdl/lfc_map.svh
`ifndef LFC_MAP_SVH
`define LFC_MAP_SVH

// Register offsets (byte addresses on the plain register port).
`define LFC_ADDR_CTRL_A 4'h0
`define LFC_ADDR_CTRL_B 4'h1
`define LFC_ADDR_CONTRAST 4'h2
`define LFC_ADDR_FRAME_LEN 4'h3
`define LFC_ADDR_STATUS 4'h4
`define LFC_ADDR_MEM_BASE 4'h8
`define LFC_MEM_WORDS 4'h7

// Control register A fields.
`define LFC_A_ENABLE 7
`define LFC_A_LOW_POWER 6
`define LFC_A_FLAG 4
`define LFC_A_IRQ_EN 3
`define LFC_A_BLANK 0
`define LFC_A_WMASK 8'hC9

// Control register B fields.
`define LFC_B_CLK_SEL 7
`define LFC_B_HALF_BIAS 6
`define LFC_B_DUTY_HI 5
`define LFC_B_DUTY_LO 4
`define LFC_B_WMASK 8'hF7

// Other field masks and reset values.
`define LFC_CONTRAST_WMASK 8'h0F
`define LFC_RESET_BYTE 8'h00
`define LFC_FRAME_LEN_RESET 8'h0F
// Shortest frame in ticks minus one, long enough for the memory copy to finish.
`define LFC_FRAME_MIN_TICKS 8'h0F

// Segment counts per port mask code.
`define LFC_SEG_BASE 5'h0D
`define LFC_SEG_24 5'h18
`define LFC_SEG_25 5'h19
`define LFC_SEG_PINS 25

`endif

// File: hdl/lfc_pkg.sv
package lfc_pkg;
    typedef enum logic [2:0] {
        LFC_OFF = 3'h1,
        LFC_RUN = 3'h2,
        LFC_BLANKED = 3'h4
    } lfc_state_t;
endpackage

// File: hdl/lfc_display_mem.sv
`include "lfc_map.svh"

module lfc_display_mem
    import lfc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic wr_en,
    input wire logic [2:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [2:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [0:6];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        rd_data <= mem[rd_addr];
    end
endmodule

// File: dv/lfc_glass.sv
module lfc_glass (
    input wire logic sys_clk,
    input wire logic blanked,
    input wire logic [3:0] common_enable,
    output int lit
);
    timeunit 1ns;
    timeprecision 1ns;
    // Counts cycles in which the glass is driven and not held at ground.
    initial lit = 0;
    always @(posedge sys_clk) begin
        if (common_enable != 4'h0 && !blanked) lit <= lit + 1;
    end
endmodule

// File: dv/lfc_checker_sva.sv
module lfc_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic global_irq_enable,
    input wire logic irq_vector_taken,
    input wire logic frame_irq,
    input wire logic frame_start,
    input wire logic display_active,
    input wire logic [3:0] common_enable,
    input wire logic [24:0] segment_enable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_idle_rdata: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data without read");
    a_rsvd_a_zero: assert property ($past(reg_rd) && $past(reg_addr) == 4'h0 |-> (reg_rdata & 8'h26) == 8'h00)
        else $error("reserved bit of control A set");
    a_rsvd_b_zero: assert property ($past(reg_rd) && $past(reg_addr) == 4'h1 |-> reg_rdata[3] == 1'b0)
        else $error("reserved bit of control B set");
    a_irq_needs_gie: assert property (frame_irq |-> $past(global_irq_enable))
        else $error("interrupt without global enable");
    a_vector_clears: assert property (irq_vector_taken && !frame_start ##1 !frame_start [*4] |-> !frame_irq)
        else $error("interrupt survives vector");
    a_start_pulse: assert property (frame_start |=> !frame_start)
        else $error("frame start longer than one cycle");
    a_common_shape: assert property (common_enable inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
        else $error("bad common pattern");
    a_off_frees: assert property ($fell(display_active) |-> ##[0:2] (common_enable == 4'h0 && segment_enable == 25'h0))
        else $error("pins kept after disable");
endmodule

bind lcd_frame_control lfc_checker chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .global_irq_enable(global_irq_enable),
    .irq_vector_taken(irq_vector_taken), .frame_irq(frame_irq), .frame_start(frame_start),
    .display_active(display_active), .common_enable(common_enable), .segment_enable(segment_enable));

// File: dv/lcd_frame_control_test.sv
module lcd_frame_control_test import lfc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, rst_n, reg_wr, reg_rd, global_irq_enable, irq_vector_taken, b;
    logic async_osc_clk, ext_clock_pin, ext_clock_input_enable, osc_on, ext_on;
    logic frame_irq, frame_start, display_active, blanked, low_power_wave, half_bias;
    logic [3:0] reg_addr, contrast_latched, common_enable;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic [24:0] segment_enable;
    logic [55:0] display_latched, mem;
    logic [31:0] r;
    int n_fail = 0, checks = 0, cyc = 0, n, f, lit;
    lcd_frame_control dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .global_irq_enable(global_irq_enable),
        .irq_vector_taken(irq_vector_taken), .async_osc_clk(async_osc_clk), .ext_clock_pin(ext_clock_pin),
        .ext_clock_input_enable(ext_clock_input_enable), .frame_irq(frame_irq), .frame_start(frame_start),
        .display_active(display_active), .blanked(blanked), .low_power_wave(low_power_wave),
        .half_bias(half_bias), .contrast_latched(contrast_latched), .common_enable(common_enable),
        .segment_enable(segment_enable), .display_latched(display_latched));
    lfc_glass glass_u (.sys_clk(sys_clk), .blanked(blanked), .common_enable(common_enable), .lit(lit));
    always #20 sys_clk = ~sys_clk;
    always #200 async_osc_clk = osc_on ? ~async_osc_clk : 1'b0;
    always #260 ext_clock_pin = ext_on ? ~ext_clock_pin : 1'b0;
    task automatic summarize();
        $display("checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [3:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
        @(posedge sys_clk);
    endtask
    task automatic wait_start();
        do begin
            @(posedge sys_clk);
            #1;
        end while (frame_start !== 1'b1);
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    // Counts frame starts and interrupt rises, taking the vector for each.
    task automatic count_events(input int len, output int k, output int m);
        logic p;
        k = 0;
        m = 0;
        p = 1'b0;
        repeat (len) begin
            @(posedge sys_clk);
            #1;
            if (frame_start === 1'b1) k++;
            if (frame_irq === 1'b1 && !p) m++;
            p = frame_irq === 1'b1;
            irq_vector_taken <= p && !irq_vector_taken;
        end
        @(posedge sys_clk);
        irq_vector_taken <= 1'b0;
    endtask
    function automatic logic [24:0] exp_seg(input logic [2:0] c);
        int w;
        w = (c < 3'h6) ? 13 + 2 * c : 18 + c;
        exp_seg = 25'((26'h1 << w) - 26'h1);
    endfunction
    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        {reg_wr, reg_rd, global_irq_enable, irq_vector_taken, b} = 5'h00;
        {async_osc_clk, ext_clock_pin, ext_clock_input_enable, osc_on, ext_on} = 5'h00;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        r = $urandom(75);
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(4'h0);
        check(d, 8'h00);
        rd(4'h1);
        check(d, 8'h00);
        rd(4'hF);
        check(d, 8'h00);
        repeat (6) begin
            r = $urandom;
            wr(4'h0, r[7:0] & 8'h7F);
            rd(4'h0);
            check(d, r[7:0] & 8'h49);
            wr(4'h1, r[15:8]);
            rd(4'h1);
            check(d, r[15:8] & 8'hF7);
        end
        wr(4'h3, 8'h3F);
        for (int i = 0; i < 8; i++) begin
            b = i[2] & (i[1:0] != 2'h0);
            wr(4'h1, {1'b0, i[2], i[1:0], 1'b0, i[2:0]});
            wr(4'h0, 8'h80);
            wait_start();
            check(common_enable, 4'hF >> (2'h3 - i[1:0]));
            check(segment_enable, exp_seg(i[2:0]));
            check(half_bias, b);
            wr(4'h0, 8'h00);
            repeat (3) @(posedge sys_clk);
            check({display_active, common_enable, segment_enable}, 30'h0);
        end
        r = $urandom;
        wr(4'h2, r[7:0]);
        for (int j = 0; j < 7; j++) begin
            mem[8 * j +: 8] = 8'($urandom);
            wr(4'h8 + 4'(j), mem[8 * j +: 8]);
        end
        wr(4'h0, 8'h80);
        wait_start();
        wait_start();
        rd(4'h0);
        check(d, 8'h90);
        wr(4'h0, 8'h80);
        rd(4'h0);
        check(d, 8'h90);
        wr(4'h0, 8'h90);
        rd(4'h0);
        check(d, 8'h80);
        check(display_latched, mem);
        check(contrast_latched, r[3:0]);
        wr(4'h0, 8'h88);
        count_events(640, n, f);
        check(f, 0);
        global_irq_enable <= 1'b1;
        count_events(1280, n, f);
        check(f inside {[19:22]}, 1'b1);
        wr(4'h0, 8'hC8);
        count_events(1280, n, f);
        check(low_power_wave, 1'b1);
        check(f inside {[9:12]}, 1'b1);
        wait_start();
        wr(4'h0, 8'h81);
        wait_start();
        wait_start();
        check(blanked, 1'b1);
        check(display_latched, mem);
        n = lit;
        repeat (10) @(posedge sys_clk);
        #1;
        check(lit, n);
        wr(4'h0, 8'h80);
        wait_start();
        wait_start();
        check(blanked, 1'b0);
        n = lit;
        repeat (10) @(posedge sys_clk);
        #1;
        check(lit - n, 10);
        wr(4'h0, 8'h90);
        do rd(4'h0); while (d[4] !== 1'b1);
        wr(4'h0, 8'h91);
        do rd(4'h0); while (d[4] !== 1'b1);
        repeat (2) @(posedge sys_clk);
        check(blanked, 1'b1);
        wr(4'h0, 8'h00);
        repeat (3) @(posedge sys_clk);
        check(display_active, 1'b0);
        wr(4'h3, 8'h03);
        wr(4'h1, 8'h80);
        osc_on <= 1'b1;
        wr(4'h0, 8'h80);
        count_events(1000, n, f);
        check(n > 0, 1'b1);
        osc_on <= 1'b0;
        repeat (20) @(posedge sys_clk);
        count_events(600, n, f);
        check(n, 0);
        ext_clock_input_enable <= 1'b1;
        ext_on <= 1'b1;
        count_events(1000, n, f);
        check(n > 0, 1'b1);
        summarize();
    end
endmodule
